// File: dv/scg_clk_partner.sv
// Clock sources and gated clock loads around the gating block
`default_nettype none
module scg_clk_partner #(
    parameter int H12 = 140,
    parameter int H48 = 60,
    parameter int HP0 = 100,
    parameter int HP1 = 120
) (
    // Sampling clock
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       clr,
    // Sources and loads
    output var  logic       s12,
    output var  logic       s48,
    output var  logic       sp0,
    output var  logic       sp1,
    input  wire logic [4:0] gck,
    output var  logic [4:0] seen_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    // Free running sources, every edge landing on a falling edge of clk
    initial begin s12 = 1'h0; forever #(H12) s12 = ~s12; end
    initial begin s48 = 1'h0; forever #(H48) s48 = ~s48; end
    initial begin sp0 = 1'h0; forever #(HP0) sp0 = ~sp0; end
    initial begin sp1 = 1'h0; forever #(HP1) sp1 = ~sp1; end
    // Remember which loads saw a high phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seen_ff <= 5'h00;
        end else if (clr) begin
            seen_ff <= 5'h00;
        end else begin
            seen_ff <= seen_ff | gck;
        end
    end
endmodule // scg_clk_partner
`default_nettype wire

// File: dv/scg_top_sva.sv
// Bus and gating checks for the clock gating block
`default_nettype none
module scg_top_sva import scg_pkg::*; #(
    parameter logic [31:0] PER_IMPL = scg_pkg::PER_ID_MASK
) (
    // Clock, reset and bus
    input wire logic                       clk,
    input wire logic                       rst_b,
    input wire logic                       hsel,
    input wire logic [scg_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0]                 htrans,
    input wire logic                       hwrite,
    input wire logic [2:0]                 hsize,
    input wire logic [scg_pkg::DATA_W-1:0] hwdata,
    input wire logic                       hready,
    input wire logic                       hreadyout,
    input wire logic                       hresp,
    // Gating
    input wire logic                       wake_req,
    input wire logic                       proc_clk_en,
    input wire logic [31:0]                periph_clk_en
);
    logic       wp_ff;
    logic [7:0] wa_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Pending write data phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_ff <= 1'h0;
            wa_ff <= 8'h00;
        end else if (hready) begin
            wp_ff <= hsel && htrans[1] && hwrite && hsize == HSIZE_WORD;
            wa_ff <= haddr;
        end
    end
    sequence rd_taken;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence wr_taken;
        hsel && htrans[1] && hready && hwrite;
    endsequence
    sequence wr_at(logic [7:0] a);
        wp_ff && hready && wa_ff == a;
    endsequence
    rd_wait_a: assert property (rd_taken |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    wr_nowait_a: assert property (wr_taken |=> hreadyout)
        else $error("write stalled");
    resp_okay_a: assert property (hresp == HRESP_OKAY)
        else $error("response not okay");
    per_unimpl_a: assert property ((periph_clk_en & ~PER_IMPL) == 32'h0)
        else $error("unimplemented peripheral enabled");
    per_set_a: assert property (wr_at(OFF_PER_EN) |=>
        (periph_clk_en & $past(hwdata) & PER_IMPL) == ($past(hwdata) & PER_IMPL))
        else $error("peripheral enable missed");
    per_clr_a: assert property (wr_at(OFF_PER_DIS) |=>
        (periph_clk_en & $past(hwdata) & PER_IMPL) == 32'h0)
        else $error("peripheral disable missed");
    per_hold_a: assert property (!(wp_ff && hready) |=> $stable(periph_clk_en))
        else $error("peripheral enables changed alone");
    proc_stop_a: assert property (wr_at(OFF_SYS_DIS) and hwdata[0] && !wake_req
        |=> !proc_clk_en)
        else $error("processor clock not stopped");
endmodule // scg_top_sva
bind scg_top scg_top_sva #(.PER_IMPL(PER_IMPL)) u_scg_top_sva (.clk(clk), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .wake_req(wake_req), .proc_clk_en(proc_clk_en), .periph_clk_en(periph_clk_en));
`default_nettype wire

// File: dv/scg_top_tb.sv
// Self-checking bench for the clock gating block
`default_nettype none
module scg_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import scg_pkg::*;
    localparam logic [31:0] IMPL = 32'h0003_FFFC;
    logic        clk, rst_b, hsel, hwrite, hready, hreadyout, hresp;
    logic        wake_req, clr, proc_clk_en, s12, s48, sp0, sp1;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, periph_clk_en;
    logic [4:0]  gck, seen;
    int          fail_count, checked;
    assign hready = hreadyout;
    scg_top #(.PER_IMPL(IMPL)) u_scg_top (.clk(clk), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .wake_req(wake_req), .usb_12_src_clk(s12), .usb_48_src_clk(s48),
        .prog_0_src_clk(sp0), .prog_1_src_clk(sp1), .proc_clk_en(proc_clk_en),
        .usb_prog_gated_clk(gck), .periph_clk_en(periph_clk_en));
    scg_clk_partner u_scg_clk_partner (.clk(clk), .rst_b(rst_b), .clr(clr), .s12(s12),
        .s48(s48), .sp0(sp0), .sp1(sp1), .gck(gck), .seen_ff(seen));
    initial begin clk = 1'h0; forever #10 clk = ~clk; end
    // ****
    // Bus tasks
    // ****
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin @(negedge clk); n++; end while (hready !== 1'h1 && n < 20);
        if (n >= 20) fail_count++;
        @(posedge clk);
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        wait_rdy();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        xfer(1'h0, a, 32'h0);
        chk(n, e, hrdata);
    endtask
    task automatic gate_chk(input logic [4:0] m);
        clr <= 1'h1;
        @(posedge clk);
        clr <= 1'h0;
        repeat (40) @(posedge clk);
        chk("gated clocks", {27'h0, m}, {27'h0, seen});
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset;
        logic [7:0]  a [8] = '{OFF_SYS_STAT, OFF_PER_STAT, OFF_PLL_A, OFF_PWR_STAT,
                               OFF_SYS_EN, OFF_PER_DIS, 8'h0C, 8'h84};
        logic [31:0] e [8] = '{RST_SYS_STAT, RST_PER_STAT, RST_PLL, RST_PWR_STAT,
                               32'h0, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 8; i++) rdchk("reset read", a[i], e[i]);
        xfer(1'h1, OFF_SYS_STAT, 32'hFFFF_FFFF);
        rdchk("status after ro write", OFF_SYS_STAT, RST_SYS_STAT);
        $display("t_reset done");
    endtask
    task automatic t_sys;
        int          b [4] = '{USB_HOST_CLOCK_BIT, USB_DEV_CLOCK_BIT,
                               PROG_OUTPUT_0_BIT, PROG_OUTPUT_1_BIT};
        logic [4:0]  g [4] = '{5'h03, 5'h04, 5'h08, 5'h10};
        for (int i = 0; i < 4; i++) begin
            xfer(1'h1, OFF_SYS_EN, 32'h1 << b[i]);
            xfer(1'h1, OFF_SYS_EN, 32'h0);
            rdchk("status on", OFF_SYS_STAT, RST_SYS_STAT | (32'h1 << b[i]));
            gate_chk(g[i]);
            xfer(1'h1, OFF_SYS_DIS, 32'h1 << b[i]);
            xfer(1'h1, OFF_SYS_DIS, 32'h0);
            rdchk("status off", OFF_SYS_STAT, RST_SYS_STAT);
            repeat (20) @(posedge clk);
            gate_chk(5'h00);
        end
        $display("t_sys done");
    endtask
    task automatic t_proc;
        xfer(1'h1, OFF_SYS_DIS, 32'h1);
        rdchk("status idle", OFF_SYS_STAT, 32'h2);
        chk("proc enable", 32'h0, {31'h0, proc_clk_en});
        wake_req <= 1'h1;
        @(posedge clk);
        wake_req <= 1'h0;
        rdchk("status woken", OFF_SYS_STAT, RST_SYS_STAT);
        $display("t_proc done");
    endtask
    task automatic t_per;
        xfer(1'h1, OFF_PER_EN, 32'hFFFF_FFFF);
        rdchk("periph all", OFF_PER_STAT, IMPL);
        chk("periph enables", IMPL, periph_clk_en);
        xfer(1'h1, OFF_PER_DIS, 32'h0004_0014);
        xfer(1'h1, OFF_PER_EN, 32'h0);
        rdchk("periph some", OFF_PER_STAT, IMPL & ~32'h14);
        xfer(1'h1, OFF_PER_DIS, 32'hFFFF_FFFF);
        rdchk("periph none", OFF_PER_STAT, 32'h0);
        hsize <= 3'h0;
        xfer(1'h1, OFF_PER_EN, 32'hFFFF_FFFF);
        hsize <= HSIZE_WORD;
        rdchk("periph byte write", OFF_PER_STAT, 32'h0);
        $display("t_per done");
    endtask
    task automatic print_verdict;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        int cyc;
        cyc = 0;
        while (cyc < 5000) begin @(posedge clk); cyc++; end
        fail_count++;
        print_verdict();
    end
    initial begin
        {hsel, hwrite, wake_req, clr, rst_b} = 5'h00;
        haddr = 8'h00;
        htrans = 2'h0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        fail_count = 0;
        checked = 0;
        repeat (4) @(posedge clk);
        rst_b <= 1'h1;
        @(posedge clk);
        t_reset();
        t_sys();
        t_proc();
        t_per();
        print_verdict();
    end
endmodule // scg_top_tb
`default_nettype wire

// File: hw/scg_clock_gate.sv
// Glitch-free gate for one clock arriving from outside the system clock domain
`default_nettype none

module scg_clock_gate (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Source clock and control
    input  wire logic src_clk,
    input  wire logic gate_en,
    // Gated clock
    output var  logic gated_clk
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic en;
        logic out;
    } scg_gate_state_t;

    scg_gate_state_t st_ff;
    scg_gate_state_t nxt_st;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.sync1 = src_clk;
        nxt_st.sync2 = st_ff.sync1;
        if (!st_ff.sync2) begin
            nxt_st.en = gate_en; // RQ19
        end
        nxt_st.out   = st_ff.sync2 & st_ff.en; // RQ19
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign gated_clk = st_ff.out;

endmodule // scg_clock_gate

`default_nettype wire

// File: hw/scg_top.sv
// Clock gating controller with AHB-Lite register file of the power manager
//
// Operation
// RQ1: A one in the host-port bit of the enable register turns host clocks on.
// RQ2: A one in the device-port bit of the enable register turns device clock on.
// RQ3: A one in a programmable-output enable bit enables that output.
// RQ4: A one in bit 0 of the disable register stops the processor clock.
// RQ5: A one in the host-port disable bit turns host clocks off.
// RQ6: A one in the device-port disable bit turns the device clock off.
// RQ7: A one in a programmable-output disable bit disables that output.
// RQ8: System status bit 0 shows whether the processor clock runs.
// RQ9: System status host-port bit shows whether host clocks are enabled.
// RQ10: System status device-port bit shows whether device clock is enabled.
// RQ11: System status programmable bits show which outputs are enabled.
// RQ12: Ones in peripheral enable bits 2 to 31 enable those clocks.
// RQ13: Ones in peripheral disable bits 2 to 31 stop those clocks.
// RQ14: Bits of unimplemented peripheral identifiers change nothing.
// RQ15: System status reads 0x03 after reset.
// RQ16: Peripheral status reads zero after reset.
// RQ17: Peripheral status bits show which peripheral clocks are enabled.
// RQ18: Write-only registers and reserved bits read zero; reserved bits ignore writes.
// RQ19: Gated clocks start and stop only during a low source phase.
`default_nettype none

module scg_top #(
    parameter logic [31:0] PER_IMPL = scg_pkg::PER_ID_MASK
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    // AHB-Lite slave
    input  wire logic                        hsel,
    input  wire logic [scg_pkg::ADDR_W-1:0]  haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [scg_pkg::DATA_W-1:0]  hwdata,
    input  wire logic                        hready,
    output var  logic                        hreadyout,
    output var  logic                        hresp,
    output var  logic [scg_pkg::DATA_W-1:0]  hrdata,
    // Processor wake request
    input  wire logic                        wake_req,
    // Source clocks
    input  wire logic                        usb_12_src_clk,
    input  wire logic                        usb_48_src_clk,
    input  wire logic                        prog_0_src_clk,
    input  wire logic                        prog_1_src_clk,
    // Gated clocks and enables
    output var  logic                        proc_clk_en,
    output logic      [scg_pkg::GATE_N-1:0]  usb_prog_gated_clk,
    output var  logic [31:0]                 periph_clk_en
);

    import scg_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        // Bus pipeline
        logic        wr_pend;
        logic        rd_pend;
        logic [7:0]  addr;
        logic        ready;
        logic [31:0] rdata;
        // Clock enables
        logic        proc_on;
        logic        host_on;
        logic        dev_on;
        logic [1:0]  prog_on;
        logic [31:0] periph_on;
        // Configuration storage
        logic [31:0] osc_ctrl;
        logic [31:0] pll_a;
        logic [31:0] pll_b;
        logic [31:0] mck_cfg;
        logic [31:0] prog0_cfg;
        logic [31:0] prog1_cfg;
    } scg_state_t;

    scg_state_t  st_ff;
    scg_state_t  nxt_st;
    logic [31:0] sys_status;
    logic [31:0] rd_value;
    logic        addr_take;
    logic [4:0]  gate_en;
    logic [4:0]  gate_src;

    // ****************************************
    // System status word
    // ****************************************
    always_comb begin
        sys_status                      = '0; // RQ18
        sys_status[PROCESSOR_CLOCK_BIT] = st_ff.proc_on; // RQ8
        sys_status[ALWAYS_ON_BIT]       = 1'b1; // RQ15
        sys_status[USB_HOST_CLOCK_BIT]  = st_ff.host_on; // RQ9
        sys_status[USB_DEV_CLOCK_BIT]   = st_ff.dev_on; // RQ10
        sys_status[PROG_OUTPUT_0_BIT]   = st_ff.prog_on[0]; // RQ11
        sys_status[PROG_OUTPUT_1_BIT]   = st_ff.prog_on[1]; // RQ11
    end

    // ****************************************
    // Read multiplexer
    // ****************************************
    always_comb begin
        case (st_ff.addr)
            OFF_SYS_STAT: begin
                rd_value = sys_status;
            end
            OFF_PER_STAT: begin
                rd_value = st_ff.periph_on; // RQ17
            end
            OFF_OSC_CTRL: begin
                rd_value = st_ff.osc_ctrl;
            end
            OFF_MAIN_FREQ: begin
                rd_value = RST_MAIN_FREQ;
            end
            OFF_PLL_A: begin
                rd_value = st_ff.pll_a;
            end
            OFF_PLL_B: begin
                rd_value = st_ff.pll_b;
            end
            OFF_MCK_CFG: begin
                rd_value = st_ff.mck_cfg;
            end
            OFF_PROG0_CFG: begin
                rd_value = st_ff.prog0_cfg;
            end
            OFF_PROG1_CFG: begin
                rd_value = st_ff.prog1_cfg;
            end
            OFF_PWR_STAT: begin
                rd_value = RST_PWR_STAT;
            end
            OFF_IRQ_MASK: begin
                rd_value = RST_IRQ_MASK;
            end
            default: begin
                rd_value = '0; // RQ18
            end
        endcase
    end

    // ****************************************
    // Bus and register next state
    // ****************************************
    assign addr_take = hsel & htrans[1] & hready;

    always_comb begin
        nxt_st         = st_ff;
        nxt_st.wr_pend = 1'b0;
        nxt_st.rd_pend = 1'b0;
        nxt_st.ready   = 1'b1;
        // Register writes in the data phase
        if (st_ff.wr_pend) begin
            case (st_ff.addr)
                OFF_SYS_EN: begin
                    if (hwdata[USB_HOST_CLOCK_BIT]) begin
                        nxt_st.host_on = 1'b1; // RQ1
                    end
                    if (hwdata[USB_DEV_CLOCK_BIT]) begin
                        nxt_st.dev_on = 1'b1; // RQ2
                    end
                    if (hwdata[PROG_OUTPUT_0_BIT]) begin
                        nxt_st.prog_on[0] = 1'b1; // RQ3
                    end
                    if (hwdata[PROG_OUTPUT_1_BIT]) begin
                        nxt_st.prog_on[1] = 1'b1; // RQ3
                    end
                end
                OFF_SYS_DIS: begin
                    if (hwdata[PROCESSOR_CLOCK_BIT]) begin
                        nxt_st.proc_on = 1'b0; // RQ4
                    end
                    if (hwdata[USB_HOST_CLOCK_BIT]) begin
                        nxt_st.host_on = 1'b0; // RQ5
                    end
                    if (hwdata[USB_DEV_CLOCK_BIT]) begin
                        nxt_st.dev_on = 1'b0; // RQ6
                    end
                    if (hwdata[PROG_OUTPUT_0_BIT]) begin
                        nxt_st.prog_on[0] = 1'b0; // RQ7
                    end
                    if (hwdata[PROG_OUTPUT_1_BIT]) begin
                        nxt_st.prog_on[1] = 1'b0; // RQ7
                    end
                end
                OFF_PER_EN: begin
                    nxt_st.periph_on = st_ff.periph_on | (hwdata & PER_IMPL); // RQ12 RQ14
                end
                OFF_PER_DIS: begin
                    nxt_st.periph_on = st_ff.periph_on & ~(hwdata & PER_IMPL); // RQ13 RQ14
                end
                OFF_OSC_CTRL: begin
                    nxt_st.osc_ctrl = hwdata;
                end
                OFF_PLL_A: begin
                    nxt_st.pll_a = hwdata;
                end
                OFF_PLL_B: begin
                    nxt_st.pll_b = hwdata;
                end
                OFF_MCK_CFG: begin
                    nxt_st.mck_cfg = hwdata;
                end
                OFF_PROG0_CFG: begin
                    nxt_st.prog0_cfg = hwdata;
                end
                OFF_PROG1_CFG: begin
                    nxt_st.prog1_cfg = hwdata;
                end
                default: begin
                    nxt_st.addr = st_ff.addr;
                end
            endcase
        end
        // Processor wake outranks nothing but a stop in the same cycle
        if (wake_req) begin
            nxt_st.proc_on = 1'b1;
        end
        // Read data captured one cycle into the data phase
        if (st_ff.rd_pend) begin
            nxt_st.rdata = rd_value;
        end
        // New address phase
        if (addr_take) begin
            nxt_st.addr    = {haddr[7:2], 2'b00};
            nxt_st.wr_pend = hwrite & (hsize == HSIZE_WORD);
            nxt_st.rd_pend = ~hwrite;
            nxt_st.ready   = hwrite;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff           <= '0;
            st_ff.ready     <= 1'b1;
            st_ff.proc_on   <= RST_SYS_STAT[PROCESSOR_CLOCK_BIT]; // RQ15
            st_ff.periph_on <= RST_PER_STAT; // RQ16
            st_ff.osc_ctrl  <= RST_OSC_CTRL;
            st_ff.pll_a     <= RST_PLL;
            st_ff.pll_b     <= RST_PLL;
            st_ff.mck_cfg   <= RST_MCK_CFG;
            st_ff.prog0_cfg <= RST_PROG_CFG;
            st_ff.prog1_cfg <= RST_PROG_CFG;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // Gated clocks
    // ****************************************
    always_comb begin
        gate_en               = '0;
        gate_src              = '0;
        gate_en[GATE_HOST_12] = st_ff.host_on;
        gate_en[GATE_HOST_48] = st_ff.host_on;
        gate_en[GATE_DEV_48]  = st_ff.dev_on;
        gate_en[GATE_PROG_0]  = st_ff.prog_on[0];
        gate_en[GATE_PROG_1]  = st_ff.prog_on[1];
        gate_src[GATE_HOST_12] = usb_12_src_clk;
        gate_src[GATE_HOST_48] = usb_48_src_clk;
        gate_src[GATE_DEV_48]  = usb_48_src_clk;
        gate_src[GATE_PROG_0]  = prog_0_src_clk;
        gate_src[GATE_PROG_1]  = prog_1_src_clk;
    end

    for (genvar g = 0; g < GATE_N; g++) begin : g_gate
        scg_clock_gate u_gate (
            .clk       (clk),
            .rst_b     (rst_b),
            .src_clk   (gate_src[g]),
            .gate_en   (gate_en[g]),
            .gated_clk (usb_prog_gated_clk[g])
        ); // RQ19
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign hreadyout     = st_ff.ready;
    assign hresp         = HRESP_OKAY;
    assign hrdata        = st_ff.rdata;
    assign proc_clk_en   = st_ff.proc_on;
    assign periph_clk_en = st_ff.periph_on;

endmodule // scg_top

`default_nettype wire

// File: shared/scg_pkg.sv
// Constants shared by the clock gating block: register map, bit positions, reset values
`default_nettype none

package scg_pkg;

    // ****************************************
    // Bus widths
    // ****************************************
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFF_SYS_EN    = 8'h00;
    localparam logic [7:0] OFF_SYS_DIS   = 8'h04;
    localparam logic [7:0] OFF_SYS_STAT  = 8'h08;
    localparam logic [7:0] OFF_PER_EN    = 8'h10;
    localparam logic [7:0] OFF_PER_DIS   = 8'h14;
    localparam logic [7:0] OFF_PER_STAT  = 8'h18;
    localparam logic [7:0] OFF_OSC_CTRL  = 8'h20;
    localparam logic [7:0] OFF_MAIN_FREQ = 8'h24;
    localparam logic [7:0] OFF_PLL_A     = 8'h28;
    localparam logic [7:0] OFF_PLL_B     = 8'h2C;
    localparam logic [7:0] OFF_MCK_CFG   = 8'h30;
    localparam logic [7:0] OFF_PROG0_CFG = 8'h40;
    localparam logic [7:0] OFF_PROG1_CFG = 8'h44;
    localparam logic [7:0] OFF_IRQ_EN    = 8'h60;
    localparam logic [7:0] OFF_IRQ_DIS   = 8'h64;
    localparam logic [7:0] OFF_PWR_STAT  = 8'h68;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h6C;
    localparam logic [7:0] OFF_PUMP_CUR  = 8'h80;

    // ****************************************
    // System clock register bit positions
    // ****************************************
    localparam int unsigned PROCESSOR_CLOCK_BIT = 0;
    localparam int unsigned ALWAYS_ON_BIT       = 1;
    localparam int unsigned USB_HOST_CLOCK_BIT  = 6;
    localparam int unsigned USB_DEV_CLOCK_BIT   = 7;
    localparam int unsigned PROG_OUTPUT_0_BIT   = 8;
    localparam int unsigned PROG_OUTPUT_1_BIT   = 9;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [31:0] RST_SYS_STAT  = 32'h0000_0003;
    localparam logic [31:0] RST_PER_STAT  = 32'h0000_0000;
    localparam logic [31:0] RST_OSC_CTRL  = 32'h0000_0000;
    localparam logic [31:0] RST_MAIN_FREQ = 32'h0000_0000;
    localparam logic [31:0] RST_PLL       = 32'h0000_3F00;
    localparam logic [31:0] RST_MCK_CFG   = 32'h0000_0000;
    localparam logic [31:0] RST_PROG_CFG  = 32'h0000_0000;
    localparam logic [31:0] RST_PWR_STAT  = 32'h0000_0008;
    localparam logic [31:0] RST_IRQ_MASK  = 32'h0000_0000;

    // ****************************************
    // Peripheral identifiers and gated channels
    // ****************************************
    localparam logic [31:0] PER_ID_MASK   = 32'hFFFF_FFFC;
    localparam int unsigned GATE_N        = 5;
    localparam int unsigned GATE_HOST_12  = 0;
    localparam int unsigned GATE_HOST_48  = 1;
    localparam int unsigned GATE_DEV_48   = 2;
    localparam int unsigned GATE_PROG_0   = 3;
    localparam int unsigned GATE_PROG_1   = 4;

    // ****************************************
    // AHB encodings
    // ****************************************
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;
    localparam logic        HRESP_OKAY    = 1'h0;

endpackage : scg_pkg

`default_nettype wire
